// *** pkg/cic_pkg.sv ***
// package: constants and types of the converter control block
package cic_pkg;
  // serial target address
  localparam logic [6:0] TGT_ADDR  = 7'h75;
  // register offsets
  localparam logic [2:0] OFS_ID    = 3'h0;
  localparam logic [2:0] OFS_CFG   = 3'h1;
  localparam logic [2:0] OFS_FLOOR = 3'h2;
  localparam logic [2:0] OFS_ILIMB = 3'h3;
  localparam logic [2:0] OFS_ROOF  = 3'h4;
  localparam logic [2:0] OFS_STAT  = 3'h5;
  localparam logic [2:0] OFS_ILIMP = 3'h6;
  localparam logic [2:0] OFS_LOOP  = 3'h7;
  localparam int         NUM_REGS  = 8;
  // configuration field positions
  localparam int CFG_RST_BIT  = 7;
  localparam int CFG_MODE_LO  = 5;
  localparam int CFG_HIC_BIT  = 4;
  localparam int CFG_DIS_BIT  = 3;
  localparam int CFG_SSFM_BIT = 2;
  localparam int CFG_LL_LO    = 0;
  // status field positions
  localparam int STAT_TSD_BIT = 7;
  localparam int STAT_CRC_BIT = 6;
  localparam int STAT_OP_BIT  = 4;
  localparam int STAT_ILP_BIT = 3;
  localparam int STAT_PG_BIT  = 0;
  // identity value, arbitrary
  localparam logic [7:0] ID_VALUE  = 8'hA6;
  // reset values and writable bits, indexed by offset
  localparam logic [7:0] RST_CFG   = 8'h38;
  localparam logic [7:0] RST_TAB [NUM_REGS] =
    '{8'h00, RST_CFG, 8'h0B, 8'h06, 8'h0E, 8'h00, 8'h1B, 8'h40};
  localparam logic [7:0] MSK_TAB [NUM_REGS] =
    '{8'h00, 8'h7F, 8'h3F, 8'h0F, 8'h3F, 8'h00, 8'h3F, 8'hFF};
  // synchroniser reset value: serial lines idle high
  localparam logic [7:0] SYNC_RST  = 8'h03;
  // enable modes
  localparam logic [1:0] MODE_FBYP = 2'h2;
  localparam logic [1:0] MODE_SHUT = 2'h3;
  // timing
  localparam int         CLK_MHZ     = 200;
  localparam int         TRIP_DLY_NS = 200;
  localparam int         OFF_NS      = 1000;
  localparam logic [7:0] TRIP_CYC = 8'((TRIP_DLY_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] OFF_CYC  = 8'((OFF_NS * CLK_MHZ + 999) / 1000);
  // state types
  typedef enum logic [2:0] {
    P_OFF, P_START, P_RUN, P_TRIP, P_HICCUP, P_LATCH, P_TSD
  } cic_prot_st_t;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_PTR, I_WDATA, I_RDATA
  } cic_i2c_st_t;
endpackage : cic_pkg

// *** verilog/cic_prot.sv ***
// protection sequencer and power-good flag of the converter
`timescale 1ns/1ps
`default_nettype none
module cic_prot (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       soft_rst,
  input  wire logic [1:0] mode,
  input  wire logic       hiccup_en,
  input  wire logic       ot_i,
  input  wire logic       trip_i,
  input  wire logic       short_i,
  input  wire logic       vout_low_i,
  input  wire logic       vin_above_i,
  input  wire logic       ss_done_i,
  output logic            bypass_en_q,
  output logic            boost_en_q,
  output logic            ss_go_q,
  output logic            pg_q,
  output logic            tsd_ev_q,
  output logic            trip_ev_q
);
  cic_pkg::cic_prot_st_t st_q, st_d;
  cic_pkg::cic_prot_st_t fault_st;
  logic [7:0] cnt_q, cnt_d;
  logic       pg_d;

  // mode decode
  wire auto_w  = ~mode[1];
  wire shut_w  = mode == cic_pkg::MODE_SHUT;
  wire byp_sel = (mode == cic_pkg::MODE_FBYP) | (auto_w & vin_above_i);
  wire fault_w = short_i | trip_i;
  wire calm    = ~ot_i & ~soft_rst & ~shut_w;
  assign fault_st = hiccup_en ? cic_pkg::P_HICCUP : cic_pkg::P_LATCH;

  // next state: heat first, then soft reset, then commanded shutdown
  always_comb begin
    st_d  = st_q;
    cnt_d = (cnt_q != 8'h00) ? 8'(cnt_q - 8'h01) : cnt_q;
    if (ot_i) begin
      st_d = cic_pkg::P_TSD;
    end else if (soft_rst) begin
      st_d  = cic_pkg::P_OFF;
      cnt_d = cic_pkg::OFF_CYC;
    end else if (shut_w) begin
      st_d = cic_pkg::P_OFF;
    end else begin
      unique case (st_q)
        cic_pkg::P_OFF:    if (cnt_q == 8'h00) st_d = cic_pkg::P_START;
        cic_pkg::P_START: begin
          if (short_i) st_d = fault_st;
          else if (ss_done_i) st_d = cic_pkg::P_RUN;
        end
        cic_pkg::P_RUN: begin
          if (byp_sel && trip_i) begin
            st_d  = cic_pkg::P_TRIP;
            cnt_d = cic_pkg::TRIP_CYC;
          end else if (short_i) begin
            st_d = fault_st;
          end
        end
        cic_pkg::P_TRIP:   if (cnt_q == 8'h00) st_d = fault_st;
        cic_pkg::P_HICCUP: if (!fault_w) st_d = cic_pkg::P_START;
        cic_pkg::P_LATCH:  st_d = cic_pkg::P_LATCH;
        cic_pkg::P_TSD:    st_d = cic_pkg::P_START;
        default:           st_d = cic_pkg::P_OFF;
      endcase
    end
  end

  // power-good: low in every off or fault state, forced bypass holds
  always_comb begin
    pg_d = 1'b0;
    if (st_d == cic_pkg::P_RUN) begin
      if (st_q != cic_pkg::P_RUN) pg_d = 1'b1;
      else if (auto_w && vin_above_i) pg_d = 1'b1;
      else if (auto_w && vout_low_i) pg_d = 1'b0;
      else pg_d = pg_q;
    end
  end

  // registered state and switch commands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q        <= cic_pkg::P_OFF;
      cnt_q       <= cic_pkg::OFF_CYC;
      bypass_en_q <= 1'b0;
      boost_en_q  <= 1'b0;
      ss_go_q     <= 1'b0;
      pg_q        <= 1'b0;
      tsd_ev_q    <= 1'b0;
      trip_ev_q   <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      bypass_en_q <= (st_d == cic_pkg::P_RUN && byp_sel) || st_d == cic_pkg::P_TRIP;
      boost_en_q  <= st_d == cic_pkg::P_START || (st_d == cic_pkg::P_RUN && !byp_sel);
      ss_go_q     <= st_d == cic_pkg::P_START;
      pg_q        <= pg_d;
      tsd_ev_q    <= st_d == cic_pkg::P_TSD && st_q != cic_pkg::P_TSD;
      trip_ev_q   <= st_d == cic_pkg::P_TRIP && st_q != cic_pkg::P_TRIP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  trip_hold_a: assert property (
    st_q == cic_pkg::P_TRIP && cnt_q != 8'h00 && calm |=> bypass_en_q) else $error("bypass cut early");
  trip_off_a: assert property (
    st_q == cic_pkg::P_TRIP && cnt_q == 8'h00 && calm |=> !bypass_en_q ##1 !bypass_en_q)
    else $error("bypass not cut after delay");
  hic_dis_a: assert property (
    st_q == cic_pkg::P_RUN && short_i && !trip_i && !hiccup_en && calm |=> st_q == cic_pkg::P_LATCH)
    else $error("disabled hiccup still retried");
  retry_a: assert property (
    st_q == cic_pkg::P_HICCUP && !fault_w && calm |=> ss_go_q && !pg_q) else $error("no soft start retry");
  tsd_back_a: assert property (
    st_q == cic_pkg::P_TSD && calm |=> ss_go_q) else $error("no restart after heat clears");
  pg_set_a: assert property (
    st_q == cic_pkg::P_START && ss_done_i && !short_i && calm |=> pg_q) else $error("pg not set");
  pg_drop_a: assert property (
    st_q == cic_pkg::P_RUN && auto_w && !vin_above_i && vout_low_i && !short_i && calm |=> !pg_q)
    else $error("pg not cleared on low output");
  pg_byp_a: assert property (
    st_q == cic_pkg::P_RUN && auto_w && vin_above_i && !fault_w && calm |=> pg_q)
    else $error("pg low in auto bypass");
endmodule : cic_prot
`default_nettype wire

// *** verilog/cic_ctrl_top.sv ***
// design: serial register target, status flags and protection of the converter
// Behaviour
// - bypass trip cuts switch after delay, then hiccup
// - short enters hiccup, restarts with soft start
// - software bit disables hiccup retry
// - over-temperature turns all switches off
// - restart automatically when over-temperature clears
// - power-good set when start-up completes
// - boost output low clears power-good
// - auto bypass holds power-good high
// - power-good unspecified in forced bypass
// - shutdown, short or heat clear power-good
// - answer target address 75h, offsets 0-7
// - standard and fast-plus rates, lines idle high
// - controller makes start/stop, busy between
// - data stable while clock high
// - eight bits, MSB first, then acknowledge
// - receiver pulls data low on ninth clock
// - target may stall by holding clock low; this block never holds the clock
// - first byte is address plus direction bit
// - undefined offset gets NACK, back to idle
// - reset bit restores defaults, cycles converter
// - mode field selects auto, bypass or shutdown
// - hiccup enable at bit four, default one
// - power-good readable at status bit zero
// - over-temperature status bit clears after read
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_top #(
  parameter logic [7:0] ID_CODE = cic_pkg::ID_VALUE // arbitrary identity value
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       over_temp_i,
  input  wire logic       bp_ilim_trip_i,
  input  wire logic       short_gnd_i,
  input  wire logic       vout_low_i,
  input  wire logic       vin_above_i,
  input  wire logic       ss_done_i,
  output logic            bypass_en,
  output logic            boost_en,
  output logic            soft_start_go,
  output logic            power_good_flag,
  output logic [7:0]      thr_floor,
  output logic [7:0]      ilim_boost,
  output logic [7:0]      thr_roof,
  output logic [7:0]      ilim_bypass,
  output logic [7:0]      loop_comp,
  output logic            discharge_en,
  output logic            ssfm_en,
  output logic [1:0]      light_mode
);
  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]            in_s1_q;
  logic [7:0]            in_s2_q;
  logic                  scl_prev_q;
  logic                  sda_prev_q;
  cic_pkg::cic_i2c_st_t  ist_q, ist_d;
  logic [3:0]            cnt_q, cnt_d;
  logic [7:0]            sh_q, sh_d;
  logic [7:0]            tx_q, tx_d;
  logic [3:0]            ptr_q, ptr_d;
  logic                  rw_q, rw_d;
  logic                  mnack_q, mnack_d;
  logic                  sda_oe_q, oe_d;
  logic                  sda_o_q;
  logic [7:0]            reg_q [cic_pkg::NUM_REGS];
  logic                  soft_rst_q;
  logic                  over_temperature_flag_q;
  logic                  bp_trip_flag_q;
  logic                  tsd_ev;
  logic                  trip_ev;
  logic                  pg;
  logic                  byp;
  logic                  bst;
  logic                  ssg;
  logic [7:0]            stat_byte;
  logic [7:0]            rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // pin and indication synchronisers
  wire [7:0] pins_w = {ss_done_i, vin_above_i, vout_low_i, short_gnd_i,
                       bp_ilim_trip_i, over_temp_i, sda_i, scl_i};

  // two flops before anything looks at an outside level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_s1_q    <= cic_pkg::SYNC_RST;
      in_s2_q    <= cic_pkg::SYNC_RST;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      in_s1_q    <= pins_w;
      in_s2_q    <= in_s1_q;
      scl_prev_q <= in_s2_q[0];
      sda_prev_q <= in_s2_q[1];
    end
  end

  // synchronised levels
  wire scl_s     = in_s2_q[0];
  wire sda_s     = in_s2_q[1];
  wire ot_s      = in_s2_q[2];
  wire trip_s    = in_s2_q[3];
  wire short_s   = in_s2_q[4];
  wire vlow_s    = in_s2_q[5];
  wire vin_hi_s  = in_s2_q[6];
  wire ssdone_s  = in_s2_q[7];

  // clock edges and bus conditions; the clock is only watched, never held low
  wire scl_rise  = scl_s & ~scl_prev_q;
  wire scl_fall  = ~scl_s & scl_prev_q;
  wire start_c   = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c    = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // serial target decode
  wire busy      = (ist_q != cic_pkg::I_IDLE) & ~start_c & ~stop_c;
  wire bit_end   = busy & scl_fall & (cnt_q == 4'h7);
  wire ack_end   = busy & scl_fall & (cnt_q == 4'h8);
  wire addr_hit  = sh_q[7:1] == cic_pkg::TGT_ADDR;
  wire ptr_in    = sh_q[7:3] == 5'h00;
  wire ptr_ok    = ~ptr_q[3];
  wire [2:0] idx = ptr_q[2:0];

  // acknowledge only what this block can take
  wire ack_now   = (ist_q == cic_pkg::I_ADDR  & addr_hit)
                 | (ist_q == cic_pkg::I_PTR   & ptr_in)
                 | (ist_q == cic_pkg::I_WDATA & ptr_ok);

  // register strobes
  wire wr_stb    = bit_end & (ist_q == cic_pkg::I_WDATA) & ptr_ok;
  wire soft_wr   = wr_stb & (idx == cic_pkg::OFS_CFG) & sh_q[cic_pkg::CFG_RST_BIT];
  wire rd_go     = ack_end & ptr_ok
                 & ((ist_q == cic_pkg::I_ADDR & rw_q)
                 | (ist_q == cic_pkg::I_RDATA & ~mnack_q));
  wire stat_clr  = rd_go & (idx == cic_pkg::OFS_STAT);

  // status byte and read selection
  assign stat_byte = {over_temperature_flag_q, 1'b1, 1'b0, bst,
                      bp_trip_flag_q, 2'b00, pg};
  assign rd_byte   = (idx == cic_pkg::OFS_ID)   ? ID_CODE :
                     (idx == cic_pkg::OFS_STAT) ? stat_byte : reg_q[idx];

  ////////////////////////////////////////////////////////////////////////////////
  // serial target sequencing
  // sample on the clock's rising edge, drive only after its falling edge
  always_comb begin
    ist_d   = ist_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    mnack_d = mnack_q;
    oe_d    = sda_oe_q;
    if (start_c) begin
      ist_d = cic_pkg::I_ADDR;
      cnt_d = 4'hF; // the clock fall that closes the start is not a bit
      oe_d  = 1'b0;
    end else if (stop_c) begin
      ist_d = cic_pkg::I_IDLE;
      oe_d  = 1'b0;
    end else if (ist_q != cic_pkg::I_IDLE) begin
      if (scl_rise) begin
        if (cnt_q != 4'h8) sh_d = {sh_q[6:0], sda_s};
        else mnack_d = sda_s;
      end
      if (scl_fall) begin
        if (cnt_q < 4'h7) begin
          cnt_d = 4'(cnt_q + 4'h1);
          if (ist_q == cic_pkg::I_RDATA) begin
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = ~tx_q[6];
          end
        end else if (cnt_q == 4'h7) begin
          cnt_d = 4'h8;
          oe_d  = ack_now;
          if (ist_q == cic_pkg::I_ADDR) rw_d = sh_q[0];
          if (ist_q == cic_pkg::I_PTR && ptr_in) ptr_d = sh_q[3:0];
          if (wr_stb) ptr_d = 4'(ptr_q + 4'h1);
          if (!ack_now && ist_q != cic_pkg::I_RDATA) ist_d = cic_pkg::I_IDLE;
          if (ist_q == cic_pkg::I_RDATA) oe_d = 1'b0;
        end else if (cnt_q == 4'hF) begin
          cnt_d = 4'h0; // first bit of the address follows
        end else begin
          cnt_d = 4'h0;
          oe_d  = 1'b0;
          unique case (ist_q)
            cic_pkg::I_ADDR:  ist_d = rw_q ? cic_pkg::I_RDATA : cic_pkg::I_PTR;
            cic_pkg::I_PTR:   ist_d = cic_pkg::I_WDATA;
            cic_pkg::I_WDATA: ist_d = cic_pkg::I_WDATA;
            cic_pkg::I_RDATA: ist_d = mnack_q ? cic_pkg::I_IDLE : cic_pkg::I_RDATA;
            cic_pkg::I_IDLE:  ist_d = cic_pkg::I_IDLE;
            default:          ist_d = cic_pkg::I_IDLE;
          endcase
          if (rd_go) begin
            tx_d  = rd_byte;
            oe_d  = ~rd_byte[7];
            ptr_d = 4'(ptr_q + 4'h1);
          end else if (ist_d == cic_pkg::I_RDATA) begin
            ist_d = cic_pkg::I_IDLE;
          end
        end
      end
    end
  end

  // serial target registers; the line is open drain, low when enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ist_q    <= cic_pkg::I_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 4'h0;
      rw_q     <= 1'b0;
      mnack_q  <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_o_q  <= 1'b0;
    end else begin
      ist_q    <= ist_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      ptr_q    <= ptr_d;
      rw_q     <= rw_d;
      mnack_q  <= mnack_d;
      sda_oe_q <= oe_d;
      sda_o_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  // write clears reserved bits; a reset-bit write restores every default
  always_ff @(posedge core_clk) begin
    if (rst || soft_wr) begin
      for (int i = 0; i < cic_pkg::NUM_REGS; i++) begin
        reg_q[i] <= cic_pkg::RST_TAB[i];
      end
    end else if (wr_stb) begin
      reg_q[idx] <= sh_q & cic_pkg::MSK_TAB[idx];
    end
  end

  // sticky status flags: a new event wins over a read that clears
  always_ff @(posedge core_clk) begin
    if (rst || soft_wr) begin
      over_temperature_flag_q <= 1'b0;
      bp_trip_flag_q          <= 1'b0;
      soft_rst_q              <= soft_wr;
    end else begin
      over_temperature_flag_q <= tsd_ev | (over_temperature_flag_q & ~stat_clr);
      bp_trip_flag_q          <= trip_ev | (bp_trip_flag_q & ~stat_clr);
      soft_rst_q              <= 1'b0;
    end
  end

  // configuration fields
  wire [7:0] cfg_w = reg_q[cic_pkg::OFS_CFG];
  wire [1:0] mode_w = cfg_w[cic_pkg::CFG_MODE_LO +: 2];
  wire hic_w = cfg_w[cic_pkg::CFG_HIC_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // protection sequencer
  cic_prot u_prot (
    .core_clk    (core_clk),
    .rst         (rst),
    .soft_rst    (soft_rst_q),
    .mode        (mode_w),
    .hiccup_en   (hic_w),
    .ot_i        (ot_s),
    .trip_i      (trip_s),
    .short_i     (short_s),
    .vout_low_i  (vlow_s),
    .vin_above_i (vin_hi_s),
    .ss_done_i   (ssdone_s),
    .bypass_en_q (byp),
    .boost_en_q  (bst),
    .ss_go_q     (ssg),
    .pg_q        (pg),
    .tsd_ev_q    (tsd_ev),
    .trip_ev_q   (trip_ev)
  );

  // outputs, each straight from a flop
  assign sda_o           = sda_o_q;
  assign sda_oe          = sda_oe_q;
  assign bypass_en       = byp;
  assign boost_en        = bst;
  assign soft_start_go   = ssg;
  assign power_good_flag = pg;
  assign thr_floor       = reg_q[cic_pkg::OFS_FLOOR];
  assign ilim_boost      = reg_q[cic_pkg::OFS_ILIMB];
  assign thr_roof        = reg_q[cic_pkg::OFS_ROOF];
  assign ilim_bypass     = reg_q[cic_pkg::OFS_ILIMP];
  assign loop_comp       = reg_q[cic_pkg::OFS_LOOP];
  assign discharge_en    = cfg_w[cic_pkg::CFG_DIS_BIT];
  assign ssfm_en         = cfg_w[cic_pkg::CFG_SSFM_BIT];
  assign light_mode      = cfg_w[cic_pkg::CFG_LL_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  heat_off_a: assert property (
    ot_s |-> ##1 (!bypass_en && !boost_en)) else $error("switches on in over-temperature");
  heat_flag_a: assert property (
    $rose(ot_s) && !soft_wr |-> ##[1:3] over_temperature_flag_q)
    else $error("over-temperature flag not set");
  flag_clear_a: assert property (
    stat_clr && !tsd_ev && !soft_wr |=> !over_temperature_flag_q)
    else $error("flag not cleared by read");
  shut_pg_a: assert property (
    mode_w == cic_pkg::MODE_SHUT && !soft_rst_q |=> !power_good_flag && !boost_en)
    else $error("pg or switching in shutdown");
  addr_ack_a: assert property (
    bit_end && ist_q == cic_pkg::I_ADDR && addr_hit |=> sda_oe ##1 (sda_oe || scl_fall))
    else $error("own address not acknowledged");
  bad_ptr_a: assert property (
    bit_end && ist_q == cic_pkg::I_PTR && !ptr_in |=> !sda_oe && ist_q == cic_pkg::I_IDLE)
    else $error("undefined offset acknowledged");
  soft_rst_a: assert property (
    soft_wr |=> reg_q[cic_pkg::OFS_CFG] == cic_pkg::RST_CFG ##1 (!bypass_en && !boost_en))
    else $error("reset bit did not restore and cycle");
  ptr_step_a: assert property (
    wr_stb && !start_c |=> ptr_q == 4'($past(ptr_q) + 4'h1)) else $error("pointer not advanced");
  id_keep_a: assert property (
    rd_go && idx == cic_pkg::OFS_ID |=> tx_q == ID_CODE) else $error("identity changed");

  // main scenarios
  wr_seen_c: cover property (wr_stb ##[1:400] rd_go);
  stat_rd_c: cover property (over_temperature_flag_q ##[1:400] stat_clr);
  trip_c:    cover property ($rose(bp_trip_flag_q));
  soft_c:    cover property (soft_wr);
endmodule : cic_ctrl_top
`default_nettype wire

// *** verification/cic_i2c_ctl.sv ***
// serial bus controller model that drives clock and data
`timescale 1ns/1ps
`default_nettype none
module cic_i2c_ctl (
  output logic     scl,
  output logic     oe,
  input  wire logic sda
);
  // clock driven high, data released and pulled high at rest
  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    #8 oe = 1'b0;
    #24 scl = 1'b1;
    #32 oe = 1'b1;
    #32 scl = 1'b0;
  endtask : start
  // one clock pulse per bit, data moved only while clock low
  task automatic bit1(input logic b, output logic r);
    #8 oe = ~b;
    #24 scl = 1'b1;
    #32 r = sda;
    scl = 1'b0;
  endtask : bit1
  // eight bits msb first, ninth bit answer; no stretching, clock is never held
  task automatic xbyte(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(w[i], s);
      r[i] = s;
    end
    bit1(m, s);
    a = ~s;
  endtask : xbyte
  // stop ends every transfer, also after a refusal
  task automatic stop();
    #8 oe = 1'b1;
    #24 scl = 1'b1;
    #32 oe = 1'b0;
    #32;
  endtask : stop
endmodule : cic_i2c_ctl
`default_nettype wire

// *** verification/cic_ctrl_top_bench.sv ***
// bench of the converter control block with a serial controller model
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_top_bench;
  logic       core_clk, rst, ot, trip, shrt, vlow, vin, ssd;
  logic       scl, m_oe, sda_o, sda_oe, byp, bst, pg, ack;
  logic       ssg, dis, ssfm;
  logic [1:0] llm;
  logic [7:0] thf, ilb, thr, ilp, lpc;
  wire  logic [43:0] outs = {thf, ilb, thr, ilp, lpc, dis, ssfm, llm};
  logic [7:0] rd;
  logic [7:0] rb [8];
  wire  logic sda;
  int         err_total, n_compared, cyc;
  localparam logic [7:0] EXP [8] = '{8'hA6, 8'h38, 8'h0B, 8'h06, 8'h0E, 8'h00, 8'h1B, 8'h40};
  // wire level: low when any party pulls, else pull-up
  assign sda = ~(m_oe | (sda_oe & ~sda_o));
  cic_i2c_ctl ctl (.scl(scl), .oe(m_oe), .sda(sda));
  cic_ctrl_top uut (.core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .over_temp_i(ot), .bp_ilim_trip_i(trip), .short_gnd_i(shrt),
    .vout_low_i(vlow), .vin_above_i(vin), .ss_done_i(ssd), .bypass_en(byp), .boost_en(bst),
    .soft_start_go(ssg), .power_good_flag(pg), .thr_floor(thf), .ilim_boost(ilb),
    .thr_roof(thr), .ilim_bypass(ilp), .loop_comp(lpc), .discharge_en(dis), .ssfm_en(ssfm),
    .light_mode(llm));
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    n_compared++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cy
  task automatic addr_ofs(input logic [7:0] o);
    ctl.start();
    ctl.xbyte({cic_pkg::TGT_ADDR, 1'b0}, 1'b1, rd, ack);
    chk("address ack", ack, 8'h01);
    ctl.xbyte(o, 1'b1, rd, ack);
  endtask : addr_ofs
  task automatic wreg(input logic [7:0] o, input logic [7:0] d);
    addr_ofs(o);
    ctl.xbyte(d, 1'b1, rd, ack);
    chk("write ack", ack, 8'h01);
    ctl.stop();
  endtask : wreg
  task automatic rseq(input logic [7:0] o, input int n);
    addr_ofs(o);
    ctl.start();
    ctl.xbyte({cic_pkg::TGT_ADDR, 1'b1}, 1'b1, rd, ack);
    for (int i = 0; i < n; i++) ctl.xbyte(8'hFF, i == n - 1, rb[i], ack);
    ctl.stop();
  endtask : rseq
  // defaults over one burst read, identity write ignored, refusals
  task automatic t_regs();
    rseq(8'h00, 8);
    for (int i = 0; i < 8; i++) if (i != 5) chk("default", rb[i], EXP[i]);
    chk("reg outputs", outs, {EXP[2], EXP[3], EXP[4], EXP[6], EXP[7], EXP[1][3:0]});
    wreg(8'h00, 8'h55);
    rseq(8'h00, 1);
    chk("identity", rb[0], EXP[0]);
    ctl.start();
    ctl.xbyte(8'hEC, 1'b1, rd, ack);
    chk("other address", ack, 8'h00);
    ctl.stop();
    addr_ofs(8'h08);
    chk("bad offset", ack, 8'h00);
    ctl.stop();
  endtask : t_regs
  // power-good after start, boost droop, auto bypass, shutdown mode
  task automatic t_pg();
    chk("pg start", pg, 8'h01);
    vlow <= 1'b1;
    cy(10);
    chk("pg droop", pg, 8'h00);
    vlow <= 1'b0;
    vin <= 1'b1;
    cy(10);
    chk("pg bypass", pg, 8'h01);
    vin <= 1'b0;
    wreg(8'h01, 8'h58);
    cy(10);
    chk("forced bypass", {byp, bst}, 8'h02);
    vin <= 1'b1;
    wreg(8'h01, 8'h7C);
    cy(10);
    chk("pg shutdown", pg, 8'h00);
    wreg(8'h01, 8'h3C);
    cy(400);
  endtask : t_pg
  // bypass trip with delayed cut, hiccup and restart
  task automatic t_trip();
    chk("bypass on", byp, 8'h01);
    trip <= 1'b1;
    cy(30);
    chk("bypass held", byp, 8'h01);
    cy(30);
    chk("bypass cut", byp, 8'h00);
    chk("pg hiccup", pg, 8'h00);
    trip <= 1'b0;
    cy(400);
    chk("pg restart", pg, 8'h01);
  endtask : t_trip
  // hiccup disabled latches a short, reset bit recovers
  task automatic t_short();
    wreg(8'h01, 8'h2C);
    chk("cfg outputs", outs[3:0], 8'h0C);
    shrt <= 1'b1;
    cy(20);
    chk("short pg", pg, 8'h00);
    shrt <= 1'b0;
    cy(400);
    chk("latched", pg, 8'h00);
    ssd <= 1'b0;
    wreg(8'h01, 8'hBC);
    rseq(8'h01, 1);
    chk("soft reset", rb[0], EXP[1]);
    chk("soft start", {ssg, pg}, 8'h02);
    ssd <= 1'b1;
    cy(400);
    chk("pg rerun", pg, 8'h01);
  endtask : t_short
  // thermal shutdown, sticky flag cleared by read, automatic restart
  task automatic t_heat();
    ot <= 1'b1;
    cy(10);
    chk("heat switches", {byp, bst, pg}, 8'h00);
    rseq(8'h05, 1);
    chk("heat flag", rb[0] & 8'h80, 8'h80);
    rseq(8'h05, 1);
    chk("heat flag read", rb[0] & 8'h80, 8'h00);
    ot <= 1'b0;
    cy(400);
    chk("heat restart", pg, 8'h01);
  endtask : t_heat
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    {rst, ot, trip, shrt, vlow, vin} = 6'h3F & 6'h20;
    ssd = 1'b1;
    cy(6);
    rst <= 1'b0;
    cy(3);
    t_regs();
    cy(300);
    t_pg();
    t_trip();
    t_short();
    t_heat();
    stop_test();
  end
endmodule : cic_ctrl_top_bench
`default_nettype wire
